// ### design/pdt_pkg.sv
/*
 * pdt_pkg: shared constants for the pio data strobe timing block:
 * register offsets, field positions, reset values, default counts and
 * the sequencer state type.
 * assumes: compiled before every other design file.
 */
package pdt_pkg;

    // register port geometry
    localparam int ADDR_W  = 8;
    localparam int DATA_W  = 32;
    localparam int FIELD_W = 7;
    localparam int PIO_W   = 16;

    // register offsets (byte addresses, one aligned word each)
    localparam logic [7:0] PDT_STB_OFS  = 8'h00;
    localparam logic [7:0] PDT_RCV_OFS  = 8'h04;
    localparam logic [7:0] PDT_CTL_OFS  = 8'h08;
    localparam logic [7:0] PDT_STAT_OFS = 8'h0c;

    // field positions inside the two timing registers
    localparam int SLV_LSB = 8;
    localparam int MST_LSB = 0;

    // writable bits of the timing registers, reserved bits read zero
    localparam logic [31:0] TIMING_MASK = 32'h00007f7f;
    localparam logic [31:0] TIMING_RST  = 32'h00000000;

    // control and status bit positions
    localparam int CTL_OVR_BIT  = 0;
    localparam int STAT_BUSY    = 0;
    localparam int STAT_DRIVE   = 1;
    localparam int STAT_OVR     = 2;

    // counts used while the override is off (cycles minus one)
    localparam logic [6:0] DEF_STB_CNT = 7'h05;
    localparam logic [6:0] DEF_RCV_CNT = 7'h03;

    // sequencer states, gray coded along idle, strobe, recover
    typedef enum logic [1:0] {
        PDT_IDLE    = 2'b00,
        PDT_STROBE  = 2'b01,
        PDT_RECOVER = 2'b11
    } pdt_state_e;

endpackage

// ### design/pdt_span_counter.sv
/*
 * pdt_span_counter: loadable down counter that times one strobe or one
 * recovery span; zero flags the last cycle of the span.
 * assumes: reset already synchronised by the instantiating module.
 */
`timescale 1ns/1ps
`default_nettype none
module pdt_span_counter (
    // clock and reset
    input  wire logic                      ref_clk,
    input  wire logic                      rst_n,
    // load side
    input  wire logic                      load,
    input  wire logic [pdt_pkg::FIELD_W-1:0] load_val,
    // state
    output logic                           count_zero
);
    import pdt_pkg::*;

    logic [FIELD_W-1:0] count_reg;

    // load wins over the decrement so back to back spans line up
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            count_reg <= 7'h00;
        end else if (load) begin
            count_reg <= load_val;
        end else if (count_reg != 7'h00) begin
            count_reg <= count_reg - 7'h01;
        end
    end

    assign count_zero = (count_reg == 7'h00);

endmodule
`default_nettype wire

// ### design/pdt_strobe_timing.sv
/*
 * pdt_strobe_timing: timing registers and strobe sequencer for pio
 * 16-bit data register transfers to the master or slave drive.
 * assumes: one clock ref_clk at 50 MHz; the controller raises one
 * transfer request at a time and holds it until xfer_ready.
 */
// Function
// RQ1: slave data accesses hold the strobe for upper strobe field plus one.
// RQ2: master data accesses hold the strobe for lower strobe field plus one.
// RQ3: slave accesses keep strobes negated upper recovery field plus one.
// RQ4: master accesses keep strobes negated lower recovery field plus one.
// RQ5: each seven bit field spans 1 to 128 clock cycles.
// RQ6: fields apply only while timing override is set, else defaults.
// RQ7: programmed widths govern 16-bit data transfers to both drives.
// RQ8: field set is chosen by the drive select of the access.
`timescale 1ns/1ps
`default_nettype none
module pdt_strobe_timing (
    // clock and reset
    input  wire logic                       ref_clk,
    input  wire logic                       resetn,
    // register port
    input  wire logic [pdt_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic [pdt_pkg::DATA_W-1:0] reg_wdata,
    input  wire logic                       reg_wr,
    input  wire logic                       reg_rd,
    output logic      [pdt_pkg::DATA_W-1:0] reg_rdata,
    // transfer request from the controller
    input  wire logic                       xfer_valid,
    input  wire logic                       xfer_write,
    input  wire logic                       xfer_drive,
    input  wire logic [pdt_pkg::PIO_W-1:0]  xfer_wdata,
    output logic                            xfer_ready,
    output logic                            xfer_done,
    output logic      [pdt_pkg::PIO_W-1:0]  xfer_rdata,
    // drive side strobes and data pins
    output logic                            drive_read_strobe,
    output logic                            drive_write_strobe,
    input  wire logic [pdt_pkg::PIO_W-1:0]  drive_data_in,
    output logic      [pdt_pkg::PIO_W-1:0]  drive_data_out,
    output logic                            drive_data_oe
);
    import pdt_pkg::*;

    logic               rst_meta_reg;
    logic               rst_n;
    logic [31:0]        strobe_width_reg;
    logic [31:0]        recovery_time_reg;
    logic               override_reg;
    pdt_state_e         state_reg;
    pdt_state_e         state_next;
    logic               write_reg;
    logic               drive_reg;
    logic               accept;
    logic               span_load;
    logic [FIELD_W-1:0] span_val;
    logic               span_zero;
    logic [FIELD_W-1:0] eff_stb;
    logic [FIELD_W-1:0] eff_rcv;
    logic               strobe_any;
    logic [31:0]        rdata_next;

    // pick the field of the addressed drive, or the default count
    function automatic logic [FIELD_W-1:0] pick_count(
        input logic [31:0]        regval,
        input logic               slave,
        input logic               ovr,
        input logic [FIELD_W-1:0] dflt
    );
        logic [FIELD_W-1:0] fld;
        fld = slave ? regval[SLV_LSB +: FIELD_W]
                    : regval[MST_LSB +: FIELD_W];
        return ovr ? fld : dflt;
    endfunction

    // reset release through two flops, assertion stays asynchronous
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rst_meta_reg <= 1'b0;
            rst_n        <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n        <= rst_meta_reg;
        end
    end

    // timing registers, reserved bits masked off on write
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            strobe_width_reg  <= TIMING_RST;
            recovery_time_reg <= TIMING_RST;
        end else if (reg_wr) begin
            if (reg_addr == PDT_STB_OFS) begin
                strobe_width_reg <= reg_wdata & TIMING_MASK;
            end
            if (reg_addr == PDT_RCV_OFS) begin
                recovery_time_reg <= reg_wdata & TIMING_MASK;
            end
        end
    end

    // override enable, held here since no other owner is wired in
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            override_reg <= 1'b0;
        end else if (reg_wr && reg_addr == PDT_CTL_OFS) begin
            override_reg <= reg_wdata[CTL_OVR_BIT];
        end
    end

    // read mux, unmapped offsets answer zero
    always_comb begin
        rdata_next = 32'h00000000;
        case (reg_addr)
            PDT_STB_OFS:  rdata_next = strobe_width_reg;
            PDT_RCV_OFS:  rdata_next = recovery_time_reg;
            PDT_CTL_OFS:  rdata_next[CTL_OVR_BIT] = override_reg;
            PDT_STAT_OFS: begin
                rdata_next[STAT_BUSY]  = (state_reg != PDT_IDLE);
                rdata_next[STAT_DRIVE] = drive_reg;
                rdata_next[STAT_OVR]   = override_reg;
            end
            default:      rdata_next = 32'h00000000;
        endcase
    end

    // read data stand for exactly the cycle after the strobe
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 32'h00000000;
        end else if (reg_rd) begin
            reg_rdata <= rdata_next;
        end else begin
            reg_rdata <= 32'h00000000;
        end
    end

    // effective counts of the drive in question
    assign eff_stb = pick_count(strobe_width_reg, xfer_drive,
                                override_reg, DEF_STB_CNT); // see RQ6
    assign eff_rcv = pick_count(recovery_time_reg, drive_reg,
                                override_reg, DEF_RCV_CNT); // see RQ6

    // a new strobe may start in idle or in the last recovery cycle
    assign xfer_ready = (state_reg == PDT_IDLE) ||
                        (state_reg == PDT_RECOVER && span_zero); // see RQ3
    assign accept     = xfer_valid && xfer_ready;

    // sequencer next state
    always_comb begin
        state_next = state_reg;
        span_load  = 1'b0;
        span_val   = eff_stb;
        case (state_reg)
            PDT_IDLE: begin
                if (accept) begin
                    state_next = PDT_STROBE;
                    span_load  = 1'b1;
                    span_val   = eff_stb; // see RQ1
                end
            end
            PDT_STROBE: begin
                if (span_zero) begin
                    state_next = PDT_RECOVER;
                    span_load  = 1'b1;
                    span_val   = eff_rcv; // see RQ4
                end
            end
            PDT_RECOVER: begin
                if (accept) begin
                    state_next = PDT_STROBE;
                    span_load  = 1'b1;
                    span_val   = eff_stb; // see RQ2
                end else if (span_zero) begin
                    state_next = PDT_IDLE;
                end
            end
            default: state_next = PDT_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= PDT_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // span timer, 0..7f gives 1..128 cycles
    pdt_span_counter u_span (
        .ref_clk    (ref_clk),
        .rst_n      (rst_n),
        .load       (span_load),
        .load_val   (span_val), // see RQ5
        .count_zero (span_zero)
    );

    // latch direction, drive and write data of the accepted transfer
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            write_reg      <= 1'b0;
            drive_reg      <= 1'b0;
            drive_data_out <= 16'h0000;
        end else if (accept) begin
            write_reg      <= xfer_write;
            drive_reg      <= xfer_drive; // see RQ8
            drive_data_out <= xfer_wdata; // see RQ7
        end
    end

    // strobes decode straight from registered state, no glitch path
    assign strobe_any         = (state_reg == PDT_STROBE);
    assign drive_read_strobe  = strobe_any && !write_reg;
    assign drive_write_strobe = strobe_any && write_reg;
    assign drive_data_oe      = drive_write_strobe; // see RQ7

    // read word caught in the last strobe cycle; done pulses after it
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            xfer_rdata <= 16'h0000;
            xfer_done  <= 1'b0;
        end else begin
            xfer_done <= strobe_any && span_zero;
            if (strobe_any && span_zero && !write_reg) begin
                xfer_rdata <= drive_data_in;
            end
        end
    end

    // helper logic for the checks: run lengths of high and low strobe
    logic [7:0]         hi_run;
    logic [7:0]         lo_run;
    logic [FIELD_W-1:0] exp_stb;
    logic [FIELD_W-1:0] exp_rcv;
    logic               prev_drive;
    logic               seen_fall;
    logic               strobe_d;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            hi_run     <= 8'h00;
            lo_run     <= 8'h00;
            exp_stb    <= 7'h00;
            exp_rcv    <= 7'h00;
            prev_drive <= 1'b0;
            seen_fall  <= 1'b0;
            strobe_d   <= 1'b0;
        end else begin
            strobe_d <= strobe_any;
            hi_run   <= strobe_any ? hi_run + 8'h01 : 8'h00;
            if (!strobe_any && lo_run != 8'hff) begin
                lo_run <= lo_run + 8'h01;
            end else if (strobe_any) begin
                lo_run <= 8'h00;
            end
            if (accept) begin
                exp_stb <= eff_stb;
            end
            if (span_load && state_reg == PDT_STROBE) begin
                exp_rcv    <= eff_rcv;
                prev_drive <= drive_reg;
                seen_fall  <= 1'b1;
            end
        end
    end

    a_slave_strobe_width: assert property ( // see RQ1
        @(posedge ref_clk) disable iff (!rst_n)
        (!strobe_any && strobe_d && drive_reg)
            |-> hi_run == {1'b0, exp_stb} + 8'h01
    ) else $error("slave strobe width wrong");

    a_master_strobe_width: assert property ( // see RQ2
        @(posedge ref_clk) disable iff (!rst_n)
        (!strobe_any && strobe_d && !drive_reg)
            |-> hi_run == {1'b0, exp_stb} + 8'h01
    ) else $error("master strobe width wrong");

    a_slave_recovery_gap: assert property ( // see RQ3
        @(posedge ref_clk) disable iff (!rst_n)
        (strobe_any && !strobe_d && seen_fall && prev_drive)
            |-> lo_run >= {1'b0, exp_rcv} + 8'h01
    ) else $error("slave recovery too short");

    a_master_recovery_gap: assert property ( // see RQ4
        @(posedge ref_clk) disable iff (!rst_n)
        (strobe_any && !strobe_d && seen_fall && !prev_drive)
            |-> lo_run >= {1'b0, exp_rcv} + 8'h01
    ) else $error("master recovery too short");

    a_width_ceiling: assert property ( // see RQ5
        @(posedge ref_clk) disable iff (!rst_n)
        strobe_any |-> hi_run < 8'h80
    ) else $error("strobe longer than 128 cycles");

    a_zero_one_cycle: assert property ( // see RQ5
        @(posedge ref_clk) disable iff (!rst_n)
        (accept && eff_stb == 7'h00) |=> strobe_any ##1 !strobe_any
    ) else $error("zero field not one cycle");

    a_override_default: assert property ( // see RQ6
        @(posedge ref_clk) disable iff (!rst_n)
        (accept && !override_reg) |=> exp_stb == DEF_STB_CNT
    ) else $error("fields used with override off");

    a_write_data_driven: assert property ( // see RQ7
        @(posedge ref_clk) disable iff (!rst_n)
        $rose(drive_write_strobe)
            |-> drive_data_oe && drive_data_out == $past(xfer_wdata)
    ) else $error("write data not on pins");

    a_drive_select: assert property ( // see RQ8
        @(posedge ref_clk) disable iff (!rst_n)
        accept |=> drive_reg == $past(xfer_drive)
    ) else $error("drive select not followed");

endmodule
`default_nettype wire

// ### test/pdt_drive_model.sv
/*
 * pdt_drive_model: behavioural pio drive sitting on the strobe pins.
 * assumes: strobes active high, one clock shared with the timing block.
 */
`timescale 1ns/1ps
`default_nettype none
module pdt_drive_model #(
    parameter logic [15:0] READ_WORD = 16'h3c5a
) (
    // clock
    input  wire logic        ref_clk,
    // strobe and data pins
    input  wire logic        drive_read_strobe,
    input  wire logic        drive_write_strobe,
    input  wire logic [15:0] drive_data_out,
    input  wire logic        drive_data_oe,
    output logic      [15:0] drive_data_in,
    // last word written by the block
    output logic      [15:0] wr_word
);
    logic [15:0] flt_reg = 16'h0000;

    // an undriven bus wanders every cycle, so stale data cannot pass
    always @(posedge ref_clk) begin
        flt_reg <= flt_reg + 16'h1357;
        if (drive_write_strobe && drive_data_oe) begin
            wr_word <= drive_data_out;
        end
    end

    // the drive answers only while the read strobe is high
    assign drive_data_in = drive_read_strobe ? READ_WORD : ~flt_reg;
endmodule
`default_nettype wire

// ### test/tb_pio_data_strobe_timing.sv
/*
 * tb_pio_data_strobe_timing: register and transfer checks of the strobe
 * timing block against a behavioural drive.
 * assumes: 50 MHz ref_clk, strobe run lengths measured at the falling edge.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_pio_data_strobe_timing;
    import pdt_pkg::*;
    localparam logic [15:0] RD_WORD = 16'h3c5a;
    logic              ref_clk = 1'b0;
    logic              resetn = 1'b0;
    logic [ADDR_W-1:0] reg_addr = 8'h00;
    logic [DATA_W-1:0] reg_wdata = 32'h00000000;
    logic              reg_wr = 1'b0;
    logic              reg_rd = 1'b0;
    logic [DATA_W-1:0] reg_rdata;
    logic              xfer_valid = 1'b0;
    logic              xfer_write = 1'b0;
    logic              xfer_drive = 1'b0;
    logic [PIO_W-1:0]  xfer_wdata = 16'h0000;
    logic              xfer_ready, xfer_done;
    logic [PIO_W-1:0]  xfer_rdata, drive_data_in, drive_data_out, wr_word;
    logic              drive_read_strobe, drive_write_strobe, drive_data_oe;
    int                err_total = 0;
    int                num_checks = 0;
    int                hi = 0;
    int                lo = 0;
    bit                armed = 0;
    int                dones = 0;
    int                widths[$];
    int                gaps[$];

    always #10 ref_clk = ~ref_clk;

    pdt_strobe_timing uut (.ref_clk(ref_clk), .resetn(resetn),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .xfer_valid(xfer_valid),
        .xfer_write(xfer_write), .xfer_drive(xfer_drive),
        .xfer_wdata(xfer_wdata), .xfer_ready(xfer_ready),
        .xfer_done(xfer_done), .xfer_rdata(xfer_rdata),
        .drive_read_strobe(drive_read_strobe),
        .drive_write_strobe(drive_write_strobe),
        .drive_data_in(drive_data_in), .drive_data_out(drive_data_out),
        .drive_data_oe(drive_data_oe));

    pdt_drive_model #(.READ_WORD(RD_WORD)) drv (.ref_clk(ref_clk),
        .drive_read_strobe(drive_read_strobe),
        .drive_write_strobe(drive_write_strobe),
        .drive_data_out(drive_data_out), .drive_data_oe(drive_data_oe),
        .drive_data_in(drive_data_in), .wr_word(wr_word));

    // strobe high and low run lengths; idle time before a run is not a gap
    always @(negedge ref_clk) begin
        if (xfer_done === 1'b1) dones++;
        if (drive_read_strobe || drive_write_strobe) begin
            if (armed && lo > 0) gaps.push_back(lo);
            lo = 0;
            hi++;
        end else begin
            if (hi > 0) widths.push_back(hi);
            if (hi > 0) armed = 1;
            hi = 0;
            lo++;
        end
    end

    task automatic stop_test();
        if (err_total == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic reg_read(input logic [7:0] a, input logic [31:0] exp);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        @(negedge ref_clk);
        check(reg_rdata, exp);
    endtask

    // request held until an edge that sees ready high takes it
    task automatic send(input logic w, input logic d, input logic last);
        logic rdy;
        int   n;
        n = 0;
        @(posedge ref_clk);
        xfer_valid <= 1'b1;
        xfer_write <= w;
        xfer_drive <= d;
        xfer_wdata <= {15'h2a6b, d};
        do begin
            @(negedge ref_clk);
            rdy = xfer_ready;
            @(posedge ref_clk);
            n++;
            if (n > 600) begin
                err_total++;
                stop_test();
            end
        end while (!rdy);
        if (last) xfer_valid <= 1'b0;
    endtask

    // two back-to-back transfers: first width, gap, second width
    task automatic run2(input logic w0, d0, w1, d1, input int ew0, eg, ew1);
        int n;
        n = 0;
        widths.delete();
        gaps.delete();
        armed = 0;
        dones = 0;
        send(w0, d0, 1'b0);
        send(w1, d1, 1'b1);
        while (widths.size() < 2) begin
            @(negedge ref_clk);
            n++;
            if (n > 600) begin
                err_total++;
                stop_test();
            end
        end
        check(widths[0], ew0);
        check(gaps[0], eg);
        check(widths[1], ew1);
        check(dones, 2);
        if (w1) check(wr_word, {15'h2a6b, d1});
        else check(xfer_rdata, RD_WORD);
    endtask

    initial begin
        repeat (5) @(posedge ref_clk);
        resetn <= 1'b1;
        repeat (3) @(posedge ref_clk);
        reg_read(PDT_STB_OFS, TIMING_RST);
        reg_read(PDT_RCV_OFS, TIMING_RST);
        reg_read(PDT_CTL_OFS, 32'h00000000);
        reg_read(8'h10, 32'h00000000);
        reg_write(PDT_STB_OFS, 32'hffffffff);
        reg_read(PDT_STB_OFS, 32'h00007f7f);
        // fields are set but ignored while the override is off
        reg_write(PDT_STB_OFS, 32'h00000303);
        reg_write(PDT_RCV_OFS, 32'h00000202);
        run2(1'b0, 1'b0, 1'b1, 1'b1, 6, 4, 6);
        // override on: each drive gets its own field set
        reg_write(PDT_CTL_OFS, 32'h00000001);
        reg_write(PDT_STB_OFS, 32'h00000301);
        reg_write(PDT_RCV_OFS, 32'h00000200);
        run2(1'b1, 1'b0, 1'b0, 1'b1, 2, 1, 4);
        run2(1'b0, 1'b1, 1'b1, 1'b0, 4, 3, 2);
        // largest field value gives the longest span
        reg_write(PDT_STB_OFS, 32'h0000007f);
        reg_write(PDT_RCV_OFS, 32'h0000007f);
        run2(1'b0, 1'b0, 1'b0, 1'b0, 128, 128, 128);
        // slave fields are zero here: one cycle strobe, one cycle gap
        run2(1'b1, 1'b1, 1'b0, 1'b0, 1, 1, 128);
        // master recovery of 128 cycles still runs: busy, master, override
        reg_read(PDT_STAT_OFS, 32'h00000005);
        repeat (140) @(posedge ref_clk);
        reg_read(PDT_STAT_OFS, 32'h00000004);
        stop_test();
    end
endmodule
`default_nettype wire
